// ### rtl/port0_mux_pkg.sv
/*
 * Constants, types and the mode decode shared by the port 0 pin mode
 * multiplexer.
 * Assumes a 200 MHz reference clock and a byte-wide register port.
 */
package port0_mux_pkg;

	// ********************************************************
	// Mode strap encodings
	// ********************************************************
	localparam logic [2:0] STRAP_MII_MAC = 3'h0;
	localparam logic [2:0] STRAP_MII_PHY = 3'h1;
	localparam logic [2:0] STRAP_TURBO_12 = 3'h2;
	localparam logic [2:0] STRAP_TURBO_16 = 3'h3;
	localparam logic [2:0] STRAP_RMII_OUT_12 = 3'h4;
	localparam logic [2:0] STRAP_RMII_OUT_16 = 3'h5;
	localparam logic [2:0] STRAP_RMII_IN = 3'h6;
	localparam logic [2:0] STRAP_RESET = 3'h0;

	// Port function after decode
	typedef enum logic [2:0] {
		MODE_MII_MAC,
		MODE_MII_PHY,
		MODE_MII_TURBO,
		MODE_RMII_OUT,
		MODE_RMII_IN,
		MODE_RESERVED
	} mode_t;

	// ********************************************************
	// Clock rates and generated clock half periods
	// ********************************************************
	localparam int unsigned REF_CLK_HZ = 200_000_000;
	localparam int unsigned MII_CLK_HZ = 25_000_000;
	localparam int unsigned FAST_CLK_HZ = 50_000_000;
	localparam int unsigned MII_HALF = REF_CLK_HZ / (2 * MII_CLK_HZ);
	localparam int unsigned FAST_HALF = REF_CLK_HZ / (2 * FAST_CLK_HZ);
	localparam int unsigned DIV_W = 3;
	localparam int unsigned START_WAIT = 2;

	// ********************************************************
	// Register map
	// ********************************************************
	localparam int unsigned REG_ADDR_W = 2;
	localparam int unsigned REG_DATA_W = 8;
	localparam logic [1:0] OFF_CTRL = 2'h0;
	localparam logic [1:0] OFF_STATUS = 2'h1;
	localparam int unsigned CTRL_ISO_BIT = 0;
	localparam int unsigned CTRL_STRENGTH_BIT = 1;
	localparam int unsigned CTRL_DIR_BIT = 2;
	localparam logic CTRL_ISO_RESET = 1'b0;
	localparam logic CTRL_STRENGTH_RESET = 1'b0;
	localparam logic CTRL_DIR_RESET = 1'b0;
	localparam int unsigned STAT_MODE_LSB = 0;
	localparam int unsigned STAT_CLK_OUT_BIT = 3;
	localparam int unsigned STAT_RESERVED_BIT = 4;
	localparam int unsigned STAT_DRIVERS_BIT = 5;

	// Strap value to port function
	function automatic mode_t decode_mode(input logic [2:0] strap);
		mode_t m;
		m = MODE_RESERVED;
		case (strap)
			STRAP_MII_MAC: m = MODE_MII_MAC;
			STRAP_MII_PHY: m = MODE_MII_PHY;
			STRAP_TURBO_12, STRAP_TURBO_16: m = MODE_MII_TURBO;
			STRAP_RMII_OUT_12, STRAP_RMII_OUT_16: m = MODE_RMII_OUT;
			STRAP_RMII_IN: m = MODE_RMII_IN;
			default: m = MODE_RESERVED;
		endcase
		return m;
	endfunction : decode_mode

endpackage : port0_mux_pkg

// ### rtl/port0_pin_mode_mux.sv
/*
 * Port 0 pin mode multiplexer: data bit 0, output valid, reference
 * clock and collision pins, steered by the latched mode strap.
 * Assumes pad cells outside that turn out/oe pairs into wires and that
 * the switch core presents one beat of data in the ref_clk domain and
 * advances when beat_take pulses.
 */
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/1ps

module port0_pin_mode_mux #(
	parameter int unsigned REF_HZ = port0_mux_pkg::REF_CLK_HZ
) (
	// Reference clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Port clock arriving through the pad input buffer
	input wire logic link_clk,
	// Straps and external reset pin
	input wire logic [2:0] port0_mode_strap,
	input wire logic external_reset_n,
	// Switch core side, ref_clk domain
	input wire logic sw_data0,
	input wire logic sw_valid,
	input wire logic sw_collision,
	output logic beat_take,
	output logic collision_seen,
	// Register port
	input wire logic [port0_mux_pkg::REG_ADDR_W-1:0] reg_addr,
	input wire logic [port0_mux_pkg::REG_DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [port0_mux_pkg::REG_DATA_W-1:0] reg_rdata,
	// Data bit 0 pin
	output logic port0_out_data_bit0,
	output logic port0_out_data_bit0_oe,
	// Output valid pin
	output logic port0_out_valid,
	output logic port0_out_valid_oe,
	// Reference clock pin and its pad controls
	output logic port0_ref_clock_out,
	output logic port0_ref_clock_oe,
	output logic ref_clock_drive_16ma,
	output logic ref_clock_in_buf_en,
	output logic ref_clock_pulldown_en,
	// Collision pin
	input wire logic port0_collision_in,
	output logic port0_collision_out,
	output logic port0_collision_oe
);
	import port0_mux_pkg::*;

	// ********************************************************
	// Parameter check
	// ********************************************************
	// The divider needs at least two cycles per fast half period
	if (REF_HZ / (2 * FAST_CLK_HZ) < 2 || REF_HZ != REF_CLK_HZ)
	begin : g_bad_ref
		$error("REF_HZ cannot produce the port clocks");
	end

	// ********************************************************
	// Link clock domain
	// ********************************************************
	// Toggles on every rising port clock edge
	logic link_toggle_ff;

	// The only state on the link clock; stops when the clock stops
	always_ff @(posedge link_clk or posedge rst)
	begin
		if (rst)
			link_toggle_ff <= 1'b0;
		else
			link_toggle_ff <= ~link_toggle_ff;
	end

	// ********************************************************
	// Synchronisers
	// ********************************************************
	logic link_s1_ff; // First stage, read only by the second
	logic link_s2_ff;
	logic link_prev_ff;
	logic [2:0] strap_s1_ff;
	logic [2:0] strap_s2_ff;
	logic ext_s1_ff;
	logic ext_s2_ff;
	logic ext_prev_ff;
	logic col_s1_ff;
	logic col_s2_ff;

	// Two flops for every pin or foreign-clock input
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			link_s1_ff <= 1'b0;
			link_s2_ff <= 1'b0;
			link_prev_ff <= 1'b0;
			strap_s1_ff <= STRAP_RESET;
			strap_s2_ff <= STRAP_RESET;
			ext_s1_ff <= 1'b0;
			ext_s2_ff <= 1'b0;
			ext_prev_ff <= 1'b0;
			col_s1_ff <= 1'b0;
			col_s2_ff <= 1'b0;
		end
		else
		begin
			link_s1_ff <= link_toggle_ff;
			link_s2_ff <= link_s1_ff;
			link_prev_ff <= link_s2_ff;
			strap_s1_ff <= port0_mode_strap;
			strap_s2_ff <= strap_s1_ff;
			ext_s1_ff <= external_reset_n;
			ext_s2_ff <= ext_s1_ff;
			ext_prev_ff <= ext_s2_ff;
			col_s1_ff <= port0_collision_in;
			col_s2_ff <= col_s1_ff;
		end
	end

	// A changed toggle marks one rising port clock edge
	wire link_edge = link_s2_ff ^ link_prev_ff;
	wire ext_release = ext_s2_ff & ~ext_prev_ff;

	// ********************************************************
	// Strap capture and control register
	// ********************************************************
	logic [1:0] start_cnt_ff; // Waits for the strap synchroniser
	logic [2:0] mode_strap_ff;
	logic iso_ff;
	logic strength_ff;
	logic dir_ff;

	// Once after power-on reset, and on each external reset release
	wire start_capture = (start_cnt_ff == 2'(START_WAIT));
	wire capture = start_capture | ext_release;
	wire ctrl_wr = reg_wr & (reg_addr == OFF_CTRL);
	// Strap low bit picks the preset drive strength
	wire strap_strength = strap_s2_ff[0];
	wire strap_dir_out = (strap_s2_ff == STRAP_RMII_OUT_12) |
		(strap_s2_ff == STRAP_RMII_OUT_16);

	// Counter stops one past the capture point
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			start_cnt_ff <= 2'h0;
		else if (start_cnt_ff <= 2'(START_WAIT))
			start_cnt_ff <= start_cnt_ff + 2'h1;
	end

	// Strap held as configuration until the next capture
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			mode_strap_ff <= STRAP_RESET;
		else if (capture)
			mode_strap_ff <= strap_s2_ff;
	end

	// Capture presets strength and direction; software may change them
	// later, but a capture in the same cycle wins over the write
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			iso_ff <= CTRL_ISO_RESET;
			strength_ff <= CTRL_STRENGTH_RESET;
			dir_ff <= CTRL_DIR_RESET;
		end
		else if (capture)
		begin
			strength_ff <= strap_strength;
			dir_ff <= strap_dir_out;
			if (ctrl_wr)
				iso_ff <= reg_wdata[CTRL_ISO_BIT];
		end
		else if (ctrl_wr)
		begin
			iso_ff <= reg_wdata[CTRL_ISO_BIT];
			strength_ff <= reg_wdata[CTRL_STRENGTH_BIT];
			dir_ff <= reg_wdata[CTRL_DIR_BIT];
		end
	end

	// ********************************************************
	// Mode decode
	// ********************************************************
	wire mode_t mode = decode_mode(mode_strap_ff);
	wire is_mac = (mode == MODE_MII_MAC);
	wire is_mii_phy = (mode == MODE_MII_PHY) | (mode == MODE_MII_TURBO);
	wire is_rmii = (mode == MODE_RMII_OUT) | (mode == MODE_RMII_IN);
	wire is_phy_side = is_mii_phy | is_rmii;
	// In RMII the direction bit, not the strap, sets the pin direction
	wire clk_is_out = is_mii_phy | (is_rmii & dir_ff);
	wire clk_is_in = is_mac | (is_rmii & ~dir_ff);
	// Isolate only matters on the PHY side
	wire drivers_on = is_phy_side & ~iso_ff;

	// ********************************************************
	// Reference clock generator
	// ********************************************************
	logic [DIV_W-1:0] div_cnt_ff;
	logic clk_gen_ff;

	// MII PHY runs at 25 MHz; turbo and RMII at 50 MHz
	wire [DIV_W-1:0] half_len = (mode == MODE_MII_PHY) ?
		DIV_W'(MII_HALF) : DIV_W'(FAST_HALF);
	// At least, not equal: a switch from 25 to 50 MHz mid phase must not
	// let the counter run on and wrap, stretching the clock high phase
	wire div_end = (div_cnt_ff >= half_len - DIV_W'(1));
	// Data launches on the falling edge for the partner's rising edge
	wire gen_fall = clk_is_out & div_end & clk_gen_ff;

	// Free-running divider while the pin is an output
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			div_cnt_ff <= '0;
			clk_gen_ff <= 1'b0;
		end
		else if (!clk_is_out)
		begin
			div_cnt_ff <= '0;
			clk_gen_ff <= 1'b0;
		end
		else if (div_end)
		begin
			div_cnt_ff <= '0;
			clk_gen_ff <= ~clk_gen_ff;
		end
		else
			div_cnt_ff <= div_cnt_ff + DIV_W'(1);
	end

	// ********************************************************
	// Beat timing and pin values
	// ********************************************************
	// One beat per port clock period, from whichever side owns it
	wire beat = gen_fall | (clk_is_in & link_edge);

	// Data bit 0: transmit bit in MAC mode, receive bit otherwise
	wire data_drive = is_mac | drivers_on;
	// Valid is transmit enable, receive valid or carrier/data valid
	wire valid_drive = is_mac | drivers_on;
	// Collision pin is only an output in MII PHY and turbo modes
	wire col_drive = is_mii_phy & ~iso_ff;
	wire clk_drive = clk_is_out & ~iso_ff;

	// Pad controls for the reference clock pin
	wire nxt_in_buf = is_mac | (is_rmii & ~dir_ff & ~iso_ff);
	wire nxt_pulldown = is_mac | (is_rmii & ~dir_ff & ~iso_ff);
	wire nxt_drive_16 = (mode == MODE_MII_TURBO) ? strength_ff :
		(is_rmii & dir_ff) ? strength_ff : 1'b0;

	// ********************************************************
	// Pin and core output flops
	// ********************************************************
	logic data_ff;
	logic data_oe_ff;
	logic valid_ff;
	logic valid_oe_ff;
	logic clk_out_ff;
	logic clk_oe_ff;
	logic col_out_ff;
	logic col_oe_ff;
	logic beat_take_ff;
	logic col_seen_ff;
	logic in_buf_ff;
	logic pulldown_ff;
	logic drive16_ff;

	// Data and valid move only on a beat, or clear in reserved mode, so they
	// stay put for the whole port clock period the partner samples them in
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			data_ff <= 1'b0;
			valid_ff <= 1'b0;
		end
		else if (!(is_mac | is_phy_side))
		begin
			data_ff <= 1'b0;
			valid_ff <= 1'b0;
		end
		else if (beat)
		begin
			data_ff <= sw_data0;
			valid_ff <= sw_valid;
		end
	end

	// Enables, clock copy and collision follow the mode every cycle
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			data_oe_ff <= 1'b0;
			valid_oe_ff <= 1'b0;
			clk_out_ff <= 1'b0;
			clk_oe_ff <= 1'b0;
			col_out_ff <= 1'b0;
			col_oe_ff <= 1'b0;
		end
		else
		begin
			data_oe_ff <= data_drive;
			valid_oe_ff <= valid_drive;
			clk_out_ff <= clk_gen_ff;
			clk_oe_ff <= clk_drive;
			col_out_ff <= col_drive & sw_collision;
			col_oe_ff <= col_drive;
		end
	end

	// Core handshake, collision report and pad controls
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			beat_take_ff <= 1'b0;
			col_seen_ff <= 1'b0;
			in_buf_ff <= 1'b0;
			pulldown_ff <= 1'b0;
			drive16_ff <= 1'b0;
		end
		else
		begin
			beat_take_ff <= beat;
			col_seen_ff <= is_mac & col_s2_ff;
			in_buf_ff <= nxt_in_buf;
			pulldown_ff <= nxt_pulldown;
			drive16_ff <= nxt_drive_16;
		end
	end

	// ********************************************************
	// Register read port
	// ********************************************************
	logic [REG_DATA_W-1:0] rdata_ff;

	wire [REG_DATA_W-1:0] ctrl_word = REG_DATA_W'({dir_ff, strength_ff,
		iso_ff});
	wire [REG_DATA_W-1:0] status_word = REG_DATA_W'({drivers_on,
		mode == MODE_RESERVED, clk_is_out, mode_strap_ff});
	// Unmapped offsets read as zero
	wire [REG_DATA_W-1:0] nxt_rdata =
		(reg_addr == OFF_CTRL) ? ctrl_word :
		(reg_addr == OFF_STATUS) ? status_word : '0;

	// Read data stands for exactly the cycle after the strobe
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			rdata_ff <= '0;
		else if (reg_rd)
			rdata_ff <= nxt_rdata;
		else
			rdata_ff <= '0;
	end

	// ********************************************************
	// Output wiring
	// ********************************************************
	assign port0_out_data_bit0 = data_ff;
	assign port0_out_data_bit0_oe = data_oe_ff;
	assign port0_out_valid = valid_ff;
	assign port0_out_valid_oe = valid_oe_ff;
	assign port0_ref_clock_out = clk_out_ff;
	assign port0_ref_clock_oe = clk_oe_ff;
	assign ref_clock_drive_16ma = drive16_ff;
	assign ref_clock_in_buf_en = in_buf_ff;
	assign ref_clock_pulldown_en = pulldown_ff;
	assign port0_collision_out = col_out_ff;
	assign port0_collision_oe = col_oe_ff;
	assign beat_take = beat_take_ff;
	assign collision_seen = col_seen_ff;
	assign reg_rdata = rdata_ff;

endmodule : port0_pin_mode_mux

// ### testbench/port0_pin_mode_mux_props.sv
/*
 * Checker for the port 0 pin mode multiplexer, bound to its ports.
 * Assumes the pad controls are registered in the ref_clk domain.
 */
`timescale 1ns/1ps
module port0_pin_mode_mux_props (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Register port
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// Beat and data pins
	input wire logic beat_take,
	input wire logic port0_out_data_bit0,
	input wire logic port0_out_data_bit0_oe,
	input wire logic port0_out_valid_oe,
	// Clock pin pads
	input wire logic port0_ref_clock_out,
	input wire logic port0_ref_clock_oe,
	input wire logic ref_clock_drive_16ma,
	input wire logic ref_clock_in_buf_en,
	input wire logic ref_clock_pulldown_en,
	// Collision
	input wire logic port0_collision_oe,
	input wire logic collision_seen
);
	// ****
	// Assertions
	// ****
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	rdata_idle_a: assert property // Read data only after a read
		(!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("rdata not idle");
	beat_gap_a: assert property (
		beat_take |=> !beat_take [*3]) else $error("beats too close");
	data_at_beat_a: assert property (
		$changed(port0_out_data_bit0) && port0_out_data_bit0_oe
		&& $past(port0_out_data_bit0_oe) |-> beat_take)
		else $error("data moved off beat");
	oe_pair_a: assert property (
		port0_out_data_bit0_oe == port0_out_valid_oe)
		else $error("data and valid enables differ");
	clk_fall_a: assert property (
		$rose(port0_ref_clock_out) && port0_ref_clock_oe |->
		##[2:4] ($fell(port0_ref_clock_out) || !port0_ref_clock_oe))
		else $error("clock high too long");
	pad_pair_a: assert property (
		ref_clock_in_buf_en == ref_clock_pulldown_en)
		else $error("buffer and pull-down differ");
	out_no_buf_a: assert property (
		port0_ref_clock_oe |-> !ref_clock_in_buf_en)
		else $error("input buffer on while driving");
	drive_out_a: assert property (
		ref_clock_drive_16ma |-> !ref_clock_in_buf_en)
		else $error("strong drive on an input clock");
	coll_phy_a: assert property (
		port0_collision_oe |-> port0_ref_clock_oe)
		else $error("collision driven outside clock-out PHY mode");
	coll_mac_a: assert property (
		collision_seen |-> !port0_collision_oe)
		else $error("collision seen while driving the pin");

	// Main scenarios reached
	beat_c: cover property (beat_take);
	coll_c: cover property (collision_seen);
	clk_c: cover property ($rose(port0_ref_clock_out) && port0_ref_clock_oe);
endmodule : port0_pin_mode_mux_props

bind port0_pin_mode_mux port0_pin_mode_mux_props i_props (
	.ref_clk(ref_clk), .rst(rst), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.beat_take(beat_take), .port0_out_data_bit0(port0_out_data_bit0),
	.port0_out_data_bit0_oe(port0_out_data_bit0_oe),
	.port0_out_valid_oe(port0_out_valid_oe),
	.port0_ref_clock_out(port0_ref_clock_out),
	.port0_ref_clock_oe(port0_ref_clock_oe),
	.ref_clock_drive_16ma(ref_clock_drive_16ma),
	.ref_clock_in_buf_en(ref_clock_in_buf_en),
	.ref_clock_pulldown_en(ref_clock_pulldown_en),
	.port0_collision_oe(port0_collision_oe),
	.collision_seen(collision_seen));

// ### testbench/port0_far_end.sv
/*
 * Far end of port 0: external PHY or MAC, clock and collision pins.
 * Assumes the device's pad enables are high while it drives.
 */
`timescale 1ns/1ps
module port0_far_end (
	// Device side of the pins
	input wire logic dev_clk,
	input wire logic dev_clk_oe,
	input wire logic in_buf_en,
	input wire logic dev_data,
	input wire logic coll_out,
	input wire logic coll_oe,
	// Bench control
	input wire logic coll_drive_en,
	input wire logic coll_val,
	// Resolved pins
	output logic link_clk,
	output logic coll_pin,
	output logic rx_bit
);
	logic gen;

	// Free-running 80 ns transmit clock, phase unrelated to ref_clk
	initial
	begin
		gen = 1'b0;
		#3;
		forever #40 gen = ~gen;
	end

	// Clock pin level; buffer off reads as low from the pad
	assign link_clk = in_buf_en & (dev_clk_oe ? dev_clk : gen);
	// Collision pin has a pull-up when nobody drives it
	assign coll_pin = coll_oe ? coll_out :
		(coll_drive_en ? coll_val : 1'b1);

	// MAC samples receive data on the device's clock
	always @(posedge dev_clk)
		if (dev_clk_oe)
			rx_bit <= dev_data;
endmodule : port0_far_end

// ### testbench/test_port0_pin_mode_mux.sv
/*
 * Self-checking bench for the port 0 pin mode multiplexer.
 * Assumes the far-end model and the checker are compiled alongside.
 */
`timescale 1ns/1ps
module test_port0_pin_mode_mux;
	import port0_mux_pkg::*;
	logic ref_clk, rst, link_clk, ext_n, sw_d, sw_v, sw_coll, coll_in;
	logic reg_wr, reg_rd, far_drv, far_coll, beat, seen, rx_bit;
	logic d0, d0_oe, dv, dv_oe, ck, ck_oe, drv16, inbuf, pd, co, co_oe;
	logic [2:0] strap;
	logic [1:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata;
	int n_errors, cmp_count, cyc;
	// Expected pads {data,valid,clk oe,buf,pull-down,16mA,coll oe}
	logic [6:0] pexp [1:6] = '{7'h71, 7'h71, 7'h73, 7'h70, 7'h72, 7'h6C};

	port0_pin_mode_mux i_port0_pin_mode_mux (.ref_clk(ref_clk), .rst(rst),
		.link_clk(link_clk), .port0_mode_strap(strap),
		.external_reset_n(ext_n), .sw_data0(sw_d), .sw_valid(sw_v),
		.sw_collision(sw_coll), .beat_take(beat), .collision_seen(seen),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .port0_out_data_bit0(d0),
		.port0_out_data_bit0_oe(d0_oe), .port0_out_valid(dv),
		.port0_out_valid_oe(dv_oe), .port0_ref_clock_out(ck),
		.port0_ref_clock_oe(ck_oe), .ref_clock_drive_16ma(drv16),
		.ref_clock_in_buf_en(inbuf), .ref_clock_pulldown_en(pd),
		.port0_collision_in(coll_in), .port0_collision_out(co),
		.port0_collision_oe(co_oe));
	port0_far_end i_port0_far_end (.dev_clk(ck), .dev_clk_oe(ck_oe),
		.in_buf_en(inbuf), .dev_data(d0), .coll_out(co), .coll_oe(co_oe),
		.coll_drive_en(far_drv), .coll_val(far_coll), .link_clk(link_clk),
		.coll_pin(coll_in), .rx_bit(rx_bit));

	// ****
	// Shared tasks
	// ****
	task chk(input string w, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e)
		begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", w, e, g);
		end
	endtask : chk
	task wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		repeat (3) @(posedge ref_clk);
	endtask : wr
	task rd(input logic [1:0] a, input logic [7:0] m, input logic [7:0] e);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 chk("register", e, reg_rdata & m);
	endtask : rd
	task pads(input logic [6:0] e, input logic [6:0] m);
		#1 chk("pads", {1'b0, e}, {1'b0, m & {d0_oe, dv_oe, ck_oe, inbuf, pd,
			drv16, co_oe}});
	endtask : pads
	// Wait for n beats; a missing beat counts as a mismatch
	task beats(input int n);
		int k;
		k = 0;
		while (n > 0 && k < 500)
		begin
			@(posedge ref_clk);
			#1 k++;
			if (beat === 1'b1)
				n--;
		end
		chk("beat missing", 8'h00, {7'h0, n > 0});
	endtask : beats
	// Recapture the strap through the external reset pin
	task set_mode(input logic [2:0] m);
		@(posedge ref_clk);
		strap <= m;
		sw_d <= m[0];
		ext_n <= 1'b0;
		repeat (4) @(posedge ref_clk);
		ext_n <= 1'b1;
		repeat (12) @(posedge ref_clk);
	endtask : set_mode
	task per(input int e);
		realtime t;
		@(posedge ck);
		t = $realtime;
		@(posedge ck);
		chk("clock period", e[7:0], 8'(int'(($realtime - t) / 5.0)));
	endtask : per

	// ****
	// Scenarios
	// ****
	task t_mac;
		rd(OFF_STATUS, 8'h1F, 8'h00);
		wr(OFF_STATUS, 8'hFF);
		rd(OFF_STATUS, 8'h1F, 8'h00);
		wr(2'h3, 8'hFF);
		rd(2'h3, 8'hFF, 8'h00);
		pads(7'h6C, 7'h7F);
		beats(2);
		chk("mac data", 8'h03, {6'h0, d0, dv});
		@(posedge ref_clk);
		far_coll <= 1'b1;
		repeat (6) @(posedge ref_clk);
		#1 chk("collision seen", 8'h01, {7'h0, seen});
		@(posedge ref_clk);
		far_coll <= 1'b0;
	endtask : t_mac
	task t_modes;
		for (int m = 1; m <= 6; m++)
		begin
			set_mode(m[2:0]);
			beats(2);
			chk("data valid", {6'h0, m[0], 1'b1}, {6'h0, d0, dv});
			pads(pexp[m], 7'h7F);
			if (m < 6)
			begin
				per(m == 1 ? 8 : 4);
				chk("far end data", {7'h0, m[0]}, {7'h0, rx_bit});
			end
			if (m >= 2 && m <= 5)
				rd(OFF_CTRL, 8'h06, {5'h0, m[2], m[0], 1'b0});
		end
	endtask : t_modes
	task t_phy;
		set_mode(3'h1);
		@(posedge ref_clk);
		sw_coll <= 1'b1;
		repeat (4) @(posedge ref_clk);
		#1 chk("collision out", 8'h01, {7'h0, co});
		wr(OFF_CTRL, 8'h01);
		pads(7'h00, 7'h7F);
		wr(OFF_CTRL, 8'h00);
		sw_coll <= 1'b0;
	endtask : t_phy
	task t_rmii_in;
		set_mode(3'h6);
		wr(OFF_CTRL, 8'h01);
		pads(7'h00, 7'h7F);
		wr(OFF_CTRL, 8'h04);
		pads(7'h70, 7'h7F);
		per(4);
	endtask : t_rmii_in
	task t_reserved;
		set_mode(3'h7);
		pads(7'h00, 7'h71);
		rd(OFF_STATUS, 8'h17, 8'h17);
		set_mode(3'h0);
		pads(7'h6C, 7'h7F);
	endtask : t_reserved

	// ****
	// Run control
	// ****
	task conclude;
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : conclude

	// 200 MHz reference clock
	initial
	begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	// Hang guard, far above the few hundred cycles the run needs
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			n_errors++;
			conclude;
		end
	end
	initial
	begin
		{rst, ext_n, sw_v, far_drv} = 4'hF;
		{sw_d, sw_coll, far_coll, reg_wr, reg_rd} = 5'h00;
		strap = 3'h0;
		reg_addr = 2'h0;
		reg_wdata = 8'h00;
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		sw_d <= 1'b1;
		repeat (5) @(posedge ref_clk);
		t_mac;
		t_modes;
		t_phy;
		t_rmii_in;
		t_reserved;
		conclude;
	end
endmodule : test_port0_pin_mode_mux
